// file: core/exc_cfg.svh
`ifndef EXC_CFG_SVH
`define EXC_CFG_SVH

// Machine state bit positions.
`define MSR_CE_BIT 17
`define MSR_PR_BIT 14
`define MSR_ME_BIT 12
`define MSR_FE0_BIT 11
`define MSR_DE_BIT 9
`define MSR_FE1_BIT 8
`define MSR_RESET 32'h0000_0000

// Syndrome bit positions.
`define SYN_ILLEGAL_BIT 27
`define SYN_PRIV_BIT 26
`define SYN_TRAP_BIT 25
`define SYN_FLOAT_BIT 24
`define SYN_WRITE_BIT 23
`define SYN_COPROC_BIT 20
`define SYN_UNIMPL_BIT 19
`define SYN_DELAYED_BIT 18

// Debug control bit positions.
`define DBG_IDM_BIT 30
`define DBG_TRAP_BIT 24

// Special register numbers open to user mode, scratch 4 to 7 and the timebase for reads only.
`define SPR_PRIV_BIT 4
`define SPR_FIXED_EXC 10'h001
`define SPR_LINK 10'h008
`define SPR_COUNT 10'h009
`define SPR_USER_SCRATCH 10'h100
`define SPR_SCRATCH_4 10'h104
`define SPR_SCRATCH_7 10'h107
`define SPR_TIMEBASE_LO 10'h10C
`define SPR_TIMEBASE_HI 10'h10D

// Register byte offsets.
`define OFF_MACHINE_STATE 12'h000
`define OFF_SAVE_PC 12'h004
`define OFF_SAVE_STATE 12'h008
`define OFF_FAULT_ADDR 12'h00C
`define OFF_SYNDROME 12'h010
`define OFF_VEC_PREFIX 12'h014
`define OFF_PROG_VEC 12'h018
`define OFF_ALIGN_VEC 12'h01C
`define OFF_DEBUG_CTRL 12'h020
`define OFF_CAUSE 12'h024

`endif

// file: core/exc_pkg.sv
package exc_pkg;

   typedef enum logic [2:0] {
      PROG_NONE = 3'b000,
      PROG_ILLEGAL = 3'b001,
      PROG_PRIV = 3'b010,
      PROG_UNIMPL = 3'b011,
      PROG_TRAP = 3'b100,
      PROG_FLOAT_EN = 3'b101,
      PROG_COPROC_EN = 3'b110
   } prog_type_t;

   typedef enum logic [1:0] {
      CAUSE_NONE = 2'b00,
      CAUSE_ALIGN = 2'b01,
      CAUSE_PROGRAM = 2'b10,
      CAUSE_DEBUG = 2'b11
   } cause_t;

   typedef struct packed {
      logic [31:0] machineState;
      logic [31:0] savePc;
      logic [31:0] saveState;
      logic [31:0] faultAddr;
      logic [31:0] syndrome;
      logic [15:0] vecPrefix;
      logic [11:0] progVecOff;
      logic [11:0] alignVecOff;
      logic [31:0] debugCtrl;
      logic [1:0] feLast;
      logic [31:0] resumeAddr;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic redirect;
      logic [31:0] redirectAddr;
      logic suppress;
      logic debugIrq;
      cause_t cause;
   } exc_state_t;

endpackage

// file: core/prog_exc_classify.sv
`timescale 1ns/1ps
`include "exc_cfg.svh"

module prog_exc_classify
   import exc_pkg::*;
(
   // Instruction decode.
   input wire logic reservedIllegal,
   input wire logic unimplDefined,
   input wire logic isFloat,
   input wire logic isAlloc,
   input wire logic isPrivileged,
   input wire logic isMoveToSpecial,
   input wire logic isMoveFromSpecial,
   input wire logic [9:0] specialRegNumber,
   input wire logic trapCond,
   // Attached units.
   input wire logic fpuRecognise,
   input wire logic fpuSupport,
   input wire logic floatExcSummary,
   input wire logic cpRecognise,
   input wire logic cpSupport,
   input wire logic cpEnabled,
   input wire logic cpEnabledExc,
   // Machine state.
   input wire logic userMode,
   input wire logic floatEnable,
   input wire logic floatModeSet,
   input wire logic trapToDebugOk,
   // Result.
   output prog_type_t progType,
   output logic trapToDebug
);

   logic sprPriv;
   logic userSprOk;
   logic illegal;
   logic priv;
   logic unimpl;

   always_comb begin
      sprPriv = specialRegNumber[`SPR_PRIV_BIT];
      userSprOk = (specialRegNumber == `SPR_FIXED_EXC) || (specialRegNumber == `SPR_LINK)
         || (specialRegNumber == `SPR_COUNT) || (specialRegNumber == `SPR_USER_SCRATCH);
      if (isMoveFromSpecial) begin
         userSprOk = userSprOk || (specialRegNumber == `SPR_TIMEBASE_HI)
            || (specialRegNumber == `SPR_TIMEBASE_LO)
            || ((specialRegNumber >= `SPR_SCRATCH_4) && (specialRegNumber <= `SPR_SCRATCH_7));
      end
      illegal = reservedIllegal || unimplDefined
         || (isFloat && !fpuRecognise) || (isAlloc && !cpRecognise)
         || (userMode && (isMoveToSpecial || isMoveFromSpecial) && !sprPriv
             && !userSprOk);
      priv = userMode && (isPrivileged
         || ((isMoveToSpecial || isMoveFromSpecial) && sprPriv));
      unimpl = (isFloat && fpuRecognise && !fpuSupport && floatEnable)
         || (isAlloc && cpRecognise && !cpSupport && cpEnabled);
      trapToDebug = 1'b0;
      // A fixed order keeps one type flag per interrupt.
      if (illegal) begin
         progType = PROG_ILLEGAL;
      end else if (priv) begin
         progType = PROG_PRIV;
      end else if (unimpl) begin
         progType = PROG_UNIMPL;
      end else if (trapCond) begin
         progType = trapToDebugOk ? PROG_NONE : PROG_TRAP;
         trapToDebug = trapToDebugOk;
      end else if (isFloat && fpuSupport && floatExcSummary && floatModeSet) begin
         progType = PROG_FLOAT_EN;
      end else if (isAlloc && cpRecognise && cpSupport && cpEnabledExc) begin
         progType = PROG_COPROC_EN;
      end else begin
         progType = PROG_NONE;
      end
   end

endmodule // prog_exc_classify

// file: core/align_program_exc.sv
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
`include "exc_cfg.svh"


module align_program_exc
   import exc_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,
   // Register bus.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Instruction at execute.
   input wire logic excValid,
   input wire logic higherPending,
   input wire logic [31:0] instrAddr,
   input wire logic [31:0] operandAddr,
   // Alignment detection and operand class.
   input wire logic alignExc,
   input wire logic isFloatLdSt,
   input wire logic isStore,
   input wire logic isCacheZero,
   input wire logic isCacheInval,
   input wire logic isCoprocLdSt,
   // Instruction decode.
   input wire logic reservedIllegal,
   input wire logic unimplDefined,
   input wire logic isFloat,
   input wire logic isAlloc,
   input wire logic isPrivileged,
   input wire logic isMoveToSpecial,
   input wire logic isMoveFromSpecial,
   input wire logic [9:0] specialRegNumber,
   input wire logic trapCond,
   // Attached floating-point unit.
   input wire logic fpuRecognise,
   input wire logic fpuSupport,
   input wire logic floatExcSummary,
   // Attached coprocessor.
   input wire logic cpRecognise,
   input wire logic cpSupport,
   input wire logic cpEnabled,
   input wire logic cpEnabledExc,
   // Machine state writes from the core.
   input wire logic msrWrEn,
   input wire logic [31:0] msrWrData,
   input wire logic [31:0] msrWrResume,
   // Fetch and pipeline control.
   output logic redirect,
   output logic [31:0] redirectAddr,
   output logic suppress,
   output logic debugIrq
);

   // ************************************************************
   // Helpers
   // ************************************************************

   // A vector is the prefix, the offset and then four zero bits.
   function automatic logic [31:0] vecAddr(input logic [15:0] prefix, input logic [11:0] off);
      vecAddr = {prefix, off, 4'h0};
   endfunction

   // Only critical, machine check and debug enables survive.
   function automatic logic [31:0] msrOnTake(input logic [31:0] machine_state_reg);
      msrOnTake = 32'h0000_0000;
      msrOnTake[`MSR_CE_BIT] = machine_state_reg[`MSR_CE_BIT];
      msrOnTake[`MSR_ME_BIT] = machine_state_reg[`MSR_ME_BIT];
      msrOnTake[`MSR_DE_BIT] = machine_state_reg[`MSR_DE_BIT];
   endfunction

   // True while either float exception mode bit is set.
   function automatic logic feSet(input logic [31:0] machine_state_reg);
      feSet = machine_state_reg[`MSR_FE0_BIT] | machine_state_reg[`MSR_FE1_BIT];
   endfunction

   // ************************************************************
   // State
   // ************************************************************

   // All state is one struct, registered as a whole.
   exc_state_t s_reg;
   exc_state_t s_next;

   prog_type_t progType;
   logic trapToDebug;
   // Mode and debug enables are decoded from the registered state.
   logic userMode;
   logic trapToDebugOk;

   assign userMode = s_reg.machineState[`MSR_PR_BIT];
   // A trap becomes a debug interrupt only when all three enables are set.
   assign trapToDebugOk = s_reg.debugCtrl[`DBG_TRAP_BIT] & s_reg.debugCtrl[`DBG_IDM_BIT]
      & s_reg.machineState[`MSR_DE_BIT];

   // ************************************************************
   // Program exception classification
   // ************************************************************

   // The classifier is pure logic on the instruction now at execute.
   // No float-available bit exists here, so the float enable is held at one.
   // Mode bits come from the registered state, not from a pending write.
   prog_exc_classify classify (
      .reservedIllegal(reservedIllegal),
      .unimplDefined(unimplDefined),
      .isFloat(isFloat),
      .isAlloc(isAlloc),
      .isPrivileged(isPrivileged),
      .isMoveToSpecial(isMoveToSpecial),
      .isMoveFromSpecial(isMoveFromSpecial),
      .specialRegNumber(specialRegNumber),
      .trapCond(trapCond),
      .fpuRecognise(fpuRecognise),
      .fpuSupport(fpuSupport),
      .floatExcSummary(floatExcSummary),
      .cpRecognise(cpRecognise),
      .cpSupport(cpSupport),
      .cpEnabled(cpEnabled),
      .cpEnabledExc(cpEnabledExc),
      .userMode(userMode),
      .floatEnable(1'b1),
      .floatModeSet(feSet(s_reg.machineState)),
      .trapToDebugOk(trapToDebugOk),
      .progType(progType),
      .trapToDebug(trapToDebug)
   );

   // ************************************************************
   // Next state
   // ************************************************************

   // These decode the register bus.
   logic setupPhase;
   logic accessWrite;
   logic mapped;

   // These select the interrupt to take.
   logic takeDelayed;
   logic takeProgram;
   logic takeAlign;
   logic takeDebug;
   logic [31:0] readData;

   // This holds the syndrome of the interrupt taken.
   logic [31:0] syn;

   always_comb begin
      // Pulses last one cycle; all else holds unless changed below.
      s_next = s_reg;
      s_next.redirect = 1'b0;
      s_next.suppress = 1'b0;
      s_next.debugIrq = 1'b0;
      syn = 32'h0000_0000;

      // Register bus: ready comes one cycle after setup.
      setupPhase = psel && !penable;
      accessWrite = psel && penable && pwrite && s_reg.pready;
      // Unmapped offsets read as zero and answer with an error.
      mapped = 1'b1;
      unique case (paddr)
         `OFF_MACHINE_STATE: readData = s_reg.machineState;
         `OFF_SAVE_PC: readData = s_reg.savePc;
         `OFF_SAVE_STATE: readData = s_reg.saveState;
         `OFF_FAULT_ADDR: readData = s_reg.faultAddr;
         `OFF_SYNDROME: readData = s_reg.syndrome;
         `OFF_VEC_PREFIX: readData = {s_reg.vecPrefix, 16'h0000};
         `OFF_PROG_VEC: readData = {16'h0000, s_reg.progVecOff, 4'h0};
         `OFF_ALIGN_VEC: readData = {16'h0000, s_reg.alignVecOff, 4'h0};
         `OFF_DEBUG_CTRL: readData = s_reg.debugCtrl;
         `OFF_CAUSE: readData = {30'h0000_0000, s_reg.cause};
         default: begin
            readData = 32'h0000_0000;
            mapped = 1'b0;
         end
      endcase
      s_next.pready = setupPhase;
      // The error stands with ready for one cycle only.
      s_next.pslverr = setupPhase && !mapped;
      if (setupPhase) begin
         // Read data is caught in setup and stands through the access.
         s_next.prdata = pwrite ? 32'h0000_0000 : readData;
      end

      // A write lands only at the access edge, with ready high.
      if (accessWrite && mapped) begin
         unique case (paddr)
            `OFF_MACHINE_STATE: s_next.machineState = pwdata;
            `OFF_SAVE_PC: s_next.savePc = pwdata;
            `OFF_SAVE_STATE: s_next.saveState = pwdata;
            `OFF_FAULT_ADDR: s_next.faultAddr = pwdata;
            `OFF_SYNDROME: s_next.syndrome = pwdata;
            `OFF_VEC_PREFIX: s_next.vecPrefix = pwdata[31:16];
            `OFF_PROG_VEC: s_next.progVecOff = pwdata[15:4];
            `OFF_ALIGN_VEC: s_next.alignVecOff = pwdata[15:4];
            `OFF_DEBUG_CTRL: s_next.debugCtrl = pwdata;
            // The cause register is read only.
            default: s_next.debugCtrl = s_reg.debugCtrl;
         endcase
      end

      // The core's state write beats a bus write in the same cycle.
      if (msrWrEn) begin
         s_next.machineState = msrWrData;
         // This is kept as the save address of a later delayed interrupt.
         s_next.resumeAddr = msrWrResume;
      end

      // Mode bits going from zero to nonzero while the summary stands.
      // One cycle of history suffices: the mode bits move only by writes and by taking an interrupt.
      s_next.feLast = {s_reg.machineState[`MSR_FE1_BIT], s_reg.machineState[`MSR_FE0_BIT]};

      // Priority: delayed float, program, debug trap, then alignment.
      // An instruction at execute in the delayed cycle is dropped and refetched.
      takeDelayed = !higherPending && floatExcSummary && feSet(s_reg.machineState)
         && (s_reg.feLast == 2'b00);
      takeProgram = !takeDelayed && excValid && !higherPending
         && (progType != PROG_NONE);
      takeDebug = !takeDelayed && excValid && !higherPending && trapToDebug;
      // Alignment is the lowest case that this block handles.
      takeAlign = !takeDelayed && !takeProgram && !takeDebug && excValid
         && !higherPending && alignExc;

      // Taking a delayed, program or alignment interrupt beats a bus or core write in the same cycle.
      if (takeDelayed || takeProgram || takeAlign) begin
         s_next.saveState = s_reg.machineState;
         s_next.machineState = msrOnTake(s_reg.machineState);
         s_next.redirect = 1'b1;
      end

      // The delayed form suppresses nothing: its instruction has completed.
      if (takeDelayed) begin
         syn[`SYN_DELAYED_BIT] = 1'b1;
         syn[`SYN_FLOAT_BIT] = 1'b1;
         s_next.syndrome = syn;
         s_next.savePc = s_reg.resumeAddr;
         s_next.redirectAddr = vecAddr(s_reg.vecPrefix, s_reg.progVecOff);
         s_next.cause = CAUSE_PROGRAM;
      end else if (takeProgram) begin
         syn[`SYN_ILLEGAL_BIT] = (progType == PROG_ILLEGAL);
         syn[`SYN_PRIV_BIT] = (progType == PROG_PRIV);
         syn[`SYN_TRAP_BIT] = (progType == PROG_TRAP);
         syn[`SYN_UNIMPL_BIT] = (progType == PROG_UNIMPL);
         // Float and coprocessor flags follow the instruction class.
         syn[`SYN_FLOAT_BIT] = isFloat;
         syn[`SYN_COPROC_BIT] = isAlloc;
         s_next.syndrome = syn;
         s_next.savePc = instrAddr;
         s_next.suppress = 1'b1;
         s_next.redirectAddr = vecAddr(s_reg.vecPrefix, s_reg.progVecOff);
         s_next.cause = CAUSE_PROGRAM;
      end else if (takeAlign) begin
         // Other syndrome bits stay clear, as syn starts at zero.
         syn[`SYN_FLOAT_BIT] = isFloatLdSt;
         syn[`SYN_WRITE_BIT] = isStore || isCacheZero || isCacheInval;
         syn[`SYN_COPROC_BIT] = isCoprocLdSt;
         s_next.syndrome = syn;
         s_next.savePc = instrAddr;
         s_next.faultAddr = operandAddr;
         s_next.suppress = 1'b1;
         s_next.redirectAddr = vecAddr(s_reg.vecPrefix, s_reg.alignVecOff);
         s_next.cause = CAUSE_ALIGN;
      end else if (takeDebug) begin
         // The debug logic takes it from here; only the cause is saved.
         s_next.debugIrq = 1'b1;
         s_next.cause = CAUSE_DEBUG;
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************

   // Reset clears every register, so all outputs start low.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_reg <= '{
            machineState: `MSR_RESET,
            savePc: 32'h0000_0000,
            saveState: 32'h0000_0000,
            faultAddr: 32'h0000_0000,
            syndrome: 32'h0000_0000,
            vecPrefix: 16'h0000,
            progVecOff: 12'h000,
            alignVecOff: 12'h000,
            debugCtrl: 32'h0000_0000,
            feLast: 2'h0,
            resumeAddr: 32'h0000_0000,
            prdata: 32'h0000_0000,
            pready: 1'b0,
            pslverr: 1'b0,
            redirect: 1'b0,
            redirectAddr: 32'h0000_0000,
            suppress: 1'b0,
            debugIrq: 1'b0,
            cause: CAUSE_NONE
         };
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs come straight from the state flip-flops.
   assign prdata = s_reg.prdata;
   assign pready = s_reg.pready;
   assign pslverr = s_reg.pslverr;
   assign redirect = s_reg.redirect;
   assign redirectAddr = s_reg.redirectAddr;
   assign suppress = s_reg.suppress;
   assign debugIrq = s_reg.debugIrq;

endmodule // align_program_exc

// file: verif/far_units.sv
`timescale 1ns/1ps

module far_units (
   // Clock, reset and behaviour select.
   input wire logic clk,
   input wire logic resetn,
   input wire logic [6:0] mode,
   // Instruction class from the core.
   input wire logic isFloat,
   input wire logic isAlloc,
   // Unit answers.
   output logic fpuRecognise,
   output logic fpuSupport,
   output logic floatExcSummary,
   output logic cpRecognise,
   output logic cpSupport,
   output logic cpEnabled,
   output logic cpEnabledExc
);
   // The summary is status held in the float unit, so it lags the select by a cycle.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) floatExcSummary <= 1'b0;
      else floatExcSummary <= mode[6];
   end
   assign fpuRecognise = isFloat & mode[0];
   assign fpuSupport = isFloat & mode[0] & mode[1];
   assign cpRecognise = isAlloc & mode[2];
   assign cpSupport = isAlloc & mode[2] & mode[3];
   assign cpEnabled = mode[4];
   assign cpEnabledExc = cpSupport & mode[5];
endmodule  // far_units

// file: verif/exc_monitor.sv
`timescale 1ns/1ps

module exc_monitor (
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,
   // Register bus.
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // Exception inputs.
   input wire logic excValid,
   input wire logic higherPending,
   input wire logic reservedIllegal,
   input wire logic trapCond,
   input wire logic msrWrEn,
   // Fetch control.
   input wire logic redirect,
   input wire logic [31:0] redirectAddr,
   input wire logic suppress,
   input wire logic debugIrq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   bus_answer_a: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   bus_error_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   higher_block_a: assert property (higherPending |=> !redirect && !suppress && !debugIrq)
      else $error("interrupt taken under higher exception");
   no_cause_a: assert property (!excValid && !$past(msrWrEn) |=> !redirect && !debugIrq)
      else $error("interrupt without cause");
   illegal_taken_a: assert property (excValid && !higherPending && reservedIllegal
      && !$past(msrWrEn) |=> redirect && suppress && !debugIrq)
      else $error("illegal instruction not taken");
   suppress_pair_a: assert property (suppress |-> redirect)
      else $error("suppress without redirect");
   delayed_only_a: assert property (redirect && !suppress && !debugIrq |-> $past(msrWrEn, 2))
      else $error("unsuppressed redirect without state write");
   vector_low_a: assert property (redirect |-> redirectAddr[3:0] == 4'h0)
      else $error("vector low bits not zero");
   debug_cause_a: assert property (debugIrq |-> $past(excValid && trapCond && !higherPending))
      else $error("debug interrupt without trap");
endmodule  // exc_monitor

bind align_program_exc exc_monitor mon (
   .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .excValid(excValid), .higherPending(higherPending),
   .reservedIllegal(reservedIllegal), .trapCond(trapCond), .msrWrEn(msrWrEn),
   .redirect(redirect), .redirectAddr(redirectAddr), .suppress(suppress), .debugIrq(debugIrq)
);

// file: verif/testbench.sv
`timescale 1ns/1ps
`include "exc_cfg.svh"
`define CHK(nm, e, s) begin numChecks++; if ((s) !== (e)) begin nMismatch++; \
   $display("unexpected %s expected %h seen %h", nm, e, s); end end

module testbench
   import exc_pkg::*;
;
   localparam logic [31:0] VP = 32'h8A5C_0000, PV = 32'h0000_0660, AV = 32'h0000_0A50;
   localparam logic [31:0] U = 32'h1 << `MSR_PR_BIT, F0 = 32'h1 << `MSR_FE0_BIT;
   localparam int IL = `SYN_ILLEGAL_BIT, PR = `SYN_PRIV_BIT, UO = `SYN_UNIMPL_BIT;
   logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, instrAddr = 32'h0, operandAddr = 32'h0;
   logic [31:0] msrWrData = 32'h0, msrWrResume = 32'h0;
   logic excValid = 1'b0, higherPending = 1'b0, msrWrEn = 1'b0;
   logic [13:0] dec = 14'h0, dc;
   logic [9:0] spr = 10'h0;
   logic [6:0] pm = 7'h0;
   logic [31:0] prdata, redirectAddr, rd, ia, oa, m, radr;
   logic pready, pslverr, redirect, suppress, debugIrq, rdr, sup, dbg, err;
   logic fpuRecognise, fpuSupport, floatExcSummary, cpRecognise, cpSupport, cpEnabled;
   logic cpEnabledExc;
   int nMismatch = 0, numChecks = 0;
   always #12.5 clk = ~clk;

   align_program_exc dut (
      .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .excValid(excValid), .higherPending(higherPending), .instrAddr(instrAddr),
      .operandAddr(operandAddr), .alignExc(dec[8]), .isFloatLdSt(dec[9]), .isStore(dec[10]),
      .isCacheZero(dec[11]), .isCacheInval(dec[12]), .isCoprocLdSt(dec[13]),
      .reservedIllegal(dec[0]), .unimplDefined(dec[1]), .isFloat(dec[2]), .isAlloc(dec[3]),
      .isPrivileged(dec[4]), .isMoveToSpecial(dec[5]), .isMoveFromSpecial(dec[6]),
      .specialRegNumber(spr), .trapCond(dec[7]), .fpuRecognise(fpuRecognise),
      .fpuSupport(fpuSupport), .floatExcSummary(floatExcSummary), .cpRecognise(cpRecognise),
      .cpSupport(cpSupport), .cpEnabled(cpEnabled), .cpEnabledExc(cpEnabledExc),
      .msrWrEn(msrWrEn), .msrWrData(msrWrData), .msrWrResume(msrWrResume),
      .redirect(redirect), .redirectAddr(redirectAddr), .suppress(suppress), .debugIrq(debugIrq)
   );
   far_units far (
      .clk(clk), .resetn(resetn), .mode(pm), .isFloat(dec[2]), .isAlloc(dec[3]),
      .fpuRecognise(fpuRecognise), .fpuSupport(fpuSupport), .floatExcSummary(floatExcSummary),
      .cpRecognise(cpRecognise), .cpSupport(cpSupport), .cpEnabled(cpEnabled),
      .cpEnabledExc(cpEnabledExc)
   );

   function automatic logic [31:0] keep(input logic [31:0] v);
      return v & ((32'h1 << `MSR_CE_BIT) | (32'h1 << `MSR_ME_BIT) | (32'h1 << `MSR_DE_BIT));
   endfunction
   function automatic logic [31:0] vec(input logic [31:0] off);
      return {VP[31:16], off[15:4], 4'h0};
   endfunction
   function automatic logic [31:0] alignSyn(input logic [13:0] d);
      return ({31'h0, d[9]} << `SYN_FLOAT_BIT) | ({31'h0, |d[12:10]} << `SYN_WRITE_BIT)
         | ({31'h0, d[13]} << `SYN_COPROC_BIT);
   endfunction

   task automatic testDone();
      $display("checks %0d mismatches %0d", numChecks, nMismatch);
      if (nMismatch == 0 && numChecks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK($sformatf("reg %h", a), e, rd)
   endtask
   task automatic exc(input logic [13:0] d);
      @(posedge clk);
      dec <= d;
      instrAddr <= ia;
      operandAddr <= oa;
      excValid <= 1'b1;
      @(posedge clk);
      dec <= 14'h0;
      excValid <= 1'b0;
      @(negedge clk);
      rdr = redirect;
      sup = suppress;
      dbg = debugIrq;
      radr = redirectAddr;
      @(posedge clk);
   endtask
   task automatic prog(input logic [13:0] d, input logic [6:0] md, input logic [31:0] ms,
         input logic [9:0] sn, input int fb);
      logic [31:0] syn;
      syn = ((fb > 0) ? (32'h1 << fb) : 32'h0) | ({27'h0, d[2], 3'h0, d[3]} << `SYN_COPROC_BIT);
      apb(1'b1, `OFF_MACHINE_STATE, ms);
      pm <= md;
      spr <= sn;
      ia = $urandom & 32'hFFFF_FFFC;
      exc(d);
      pm <= 7'h0;
      if (fb < 0) begin
         `CHK("redirect", 1'b0, rdr)
      end else begin
         `CHK("suppress", 1'b1, rdr & sup)
         `CHK("target", vec(PV), radr)
         chk(`OFF_SAVE_PC, ia);
         chk(`OFF_SAVE_STATE, ms);
         chk(`OFF_MACHINE_STATE, keep(ms));
         chk(`OFF_SYNDROME, syn);
         chk(`OFF_CAUSE, {30'h0, CAUSE_PROGRAM});
      end
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      nMismatch++;
      testDone();
   end

   initial begin
      void'($urandom(32'hc368));
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      for (int a = 0; a <= 'h24; a += 4) chk(a[11:0], 32'h0);
      apb(1'b0, 12'h030, 32'h0);
      `CHK("slave error", 1'b1, err)
      `CHK("unmapped data", 32'h0, rd)
      apb(1'b1, `OFF_VEC_PREFIX, VP);
      apb(1'b1, `OFF_PROG_VEC, PV);
      apb(1'b1, `OFF_ALIGN_VEC, AV);
      apb(1'b1, `OFF_SYNDROME, 32'hFFFF_FFFF);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         m = $urandom;
         ia = $urandom & 32'hFFFF_FFFC;
         oa = $urandom;
         dc = {5'($urandom), 9'h100};
         if (i < 2) dc[13:9] = {5{i[0]}};
         apb(1'b1, `OFF_MACHINE_STATE, m);
         exc(dc);
         `CHK("suppress", 1'b1, rdr & sup)
         `CHK("target", vec(AV), radr)
         chk(`OFF_SAVE_PC, ia);
         chk(`OFF_SAVE_STATE, m);
         chk(`OFF_MACHINE_STATE, keep(m));
         chk(`OFF_FAULT_ADDR, oa);
         chk(`OFF_SYNDROME, alignSyn(dc));
      end
      $display("test alignment done");
      prog(14'h0001, 7'h00, 0, 0, IL);
      prog(14'h0002, 7'h00, 0, 0, IL);
      prog(14'h0004, 7'h00, 0, 0, IL);
      prog(14'h0008, 7'h00, 0, 0, IL);
      prog(14'h0020, 7'h00, U, 10'h002, IL);
      prog(14'h0040, 7'h00, U, 10'h104, -1);
      prog(14'h0020, 7'h00, U, 10'h009, -1);
      prog(14'h0010, 7'h00, U, 0, PR);
      prog(14'h0040, 7'h00, U, 10'h010, PR);
      prog(14'h0010, 7'h00, 0, 0, -1);
      prog(14'h0004, 7'h01, 0, 0, UO);
      prog(14'h0008, 7'h14, 0, 0, UO);
      prog(14'h0080, 7'h00, 0, 0, `SYN_TRAP_BIT);
      prog(14'h0004, 7'h43, F0, 0, 0);
      prog(14'h0004, 7'h43, 0, 0, -1);
      prog(14'h0008, 7'h3C, 0, 0, 0);
      prog(14'h0011, 7'h00, U, 0, IL);
      prog(14'h0084, 7'h01, 0, 0, UO);
      higherPending <= 1'b1;
      prog(14'h0001, 7'h00, 0, 0, -1);
      higherPending <= 1'b0;
      $display("test program done");
      apb(1'b1, `OFF_MACHINE_STATE, 32'h0);
      pm <= 7'h43;
      ia = $urandom & 32'hFFFF_FFFC;
      repeat (2) @(posedge clk);
      msrWrEn <= 1'b1;
      msrWrData <= 32'h1 << `MSR_FE1_BIT;
      msrWrResume <= ia;
      @(posedge clk);
      msrWrEn <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      `CHK("delayed redirect", 1'b1, redirect)
      `CHK("delayed suppress", 1'b0, suppress)
      `CHK("delayed target", vec(PV), redirectAddr)
      chk(`OFF_SAVE_PC, ia);
      chk(`OFF_SAVE_STATE, 32'h1 << `MSR_FE1_BIT);
      chk(`OFF_SYNDROME, (32'h1 << `SYN_DELAYED_BIT) | (32'h1 << `SYN_FLOAT_BIT));
      pm <= 7'h0;
      $display("test delayed done");
      apb(1'b1, `OFF_DEBUG_CTRL, (32'h1 << `DBG_IDM_BIT) | (32'h1 << `DBG_TRAP_BIT));
      apb(1'b1, `OFF_MACHINE_STATE, 32'h1 << `MSR_DE_BIT);
      exc(14'h0080);
      `CHK("debug", 1'b1, dbg)
      chk(`OFF_CAUSE, {30'h0, CAUSE_DEBUG});
      $display("test debug done");
      testDone();
   end
endmodule  // testbench
